// ===== logic/replay_protected_counter_gate_map.svh
// offsets, field positions, reset values and timing counts of the state gating block
`ifndef REPLAY_PROTECTED_COUNTER_GATE_MAP_SVH
`define REPLAY_PROTECTED_COUNTER_GATE_MAP_SVH
`define EXT_BUSY_BIT 0
`define EXT_STATUS_RESET 8'h00
`define ERASED_BYTE 8'hff
`define DRIVE_STRENGTH_BIT0_POS 21
`define QUAD_IO_ENABLE_POS 9
`define STATUS_REG_RESET 24'h200200
`define POWER_UP_WAIT_TIME_US 1800
`define CLK_MHZ 40
`define POWER_UP_WAIT_CYCLES (`POWER_UP_WAIT_TIME_US * `CLK_MHZ)
`endif

// ===== logic/replay_protected_counter_gate_pkg.sv
// types of the state gating block
package replay_protected_counter_gate_pkg;
  typedef enum logic [3:0] {
    cmd_counter_op = 4'h0,
    cmd_ext_status_read = 4'h1,
    cmd_status_read = 4'h2,
    cmd_array_read = 4'h3,
    cmd_write_erase = 4'h4,
    cmd_chip_erase = 4'h5,
    cmd_status_write = 4'h6,
    cmd_suspend = 4'h7,
    cmd_resume = 4'h8,
    cmd_deep_power_down = 4'h9,
    cmd_release_power_down = 4'ha
  } cmd_e;
  typedef enum logic [4:0] {
    st_idle = 5'h01,
    st_counter = 5'h02,
    st_pe = 5'h04,
    st_suspended = 5'h08,
    st_power_down = 5'h10
  } state_e;
  typedef enum logic [1:0] {
    resp_none = 2'h0,
    resp_accept = 2'h1,
    resp_ignore = 2'h2,
    resp_refuse = 2'h3
  } resp_e;
endpackage : replay_protected_counter_gate_pkg

// ===== logic/replay_protected_counter_state_gating.sv
// operation-state gating of a flash with a replay protected counter
//
// Behaviour
// [R1] deep power-down ignores counter and extended-status reads
// [R2] counter command ignores the write enable latch
// [R3] controller avoids counter commands during program/erase; bench sends them in pe and suspended states; accepted when no counter run is busy
// [R4] counter state until busy clears; suspend ignored
// [R5] program/erase state until write in progress clears
// [R6] suspended state entered when suspend-done flag sets
// [R7] suspend suspends, except chip erase or status write
// [R8] suspend refused suspended; resume rules per state
// [R9] array access gating per counter, pe, suspended state
// [R10] counter command refused while another executes
// [R11] extended read reports busy then done
// [R12] extended read in pe/suspend returns last result
// [R13] status read accepted except in deep power-down, shows busy
// [R14] erased array bytes read all ones
// [R15] status register ships zero except two bits
// [R16] controller waits power-up time before commands
// [R17] extended busy bit set during counter execution
// [R18] exactly one state; rejected commands change nothing
`timescale 1ns/1ps
`include "replay_protected_counter_gate_map.svh"

module replay_protected_counter_state_gating (
  input wire logic clk,
  input wire logic reset,
  input wire logic cmd_valid,
  input wire replay_protected_counter_gate_pkg::cmd_e cmd_kind,
  input wire logic [23:0] status_wr_data,
  input wire logic counter_exec_done,
  input wire logic [7:0] counter_result,
  input wire logic pe_done,
  output replay_protected_counter_gate_pkg::state_e state,
  output replay_protected_counter_gate_pkg::resp_e resp,
  output logic [7:0] read_data,
  output logic [7:0] ext_status,
  output logic write_in_progress,
  output logic suspend_done,
  output logic [23:0] status_reg,
  output logic [7:0] erased_byte
);
  // ==========================================
  // command decision
  replay_protected_counter_gate_pkg::resp_e next_resp;
  logic counter_busy;
  logic no_suspend;
  logic accept;
  assign counter_busy = ext_status[`EXT_BUSY_BIT];

  always_comb begin
    next_resp = replay_protected_counter_gate_pkg::resp_none;
    if (cmd_valid) begin
      next_resp = replay_protected_counter_gate_pkg::resp_accept;
      case (state)
        replay_protected_counter_gate_pkg::st_power_down: begin
          if (cmd_kind != replay_protected_counter_gate_pkg::cmd_release_power_down) begin
            next_resp = replay_protected_counter_gate_pkg::resp_ignore; // R1
          end
        end
        replay_protected_counter_gate_pkg::st_counter: begin
          case (cmd_kind)
            replay_protected_counter_gate_pkg::cmd_suspend,
            replay_protected_counter_gate_pkg::cmd_resume,
            replay_protected_counter_gate_pkg::cmd_release_power_down: next_resp = replay_protected_counter_gate_pkg::resp_ignore; // R4 R8
            replay_protected_counter_gate_pkg::cmd_counter_op,
            replay_protected_counter_gate_pkg::cmd_deep_power_down: next_resp = replay_protected_counter_gate_pkg::resp_refuse; // R10
            default: next_resp = replay_protected_counter_gate_pkg::resp_accept; // R9
          endcase
        end
        replay_protected_counter_gate_pkg::st_pe: begin
          case (cmd_kind)
            replay_protected_counter_gate_pkg::cmd_array_read,
            replay_protected_counter_gate_pkg::cmd_write_erase,
            replay_protected_counter_gate_pkg::cmd_chip_erase,
            replay_protected_counter_gate_pkg::cmd_status_write,
            replay_protected_counter_gate_pkg::cmd_resume,
            replay_protected_counter_gate_pkg::cmd_deep_power_down,
            replay_protected_counter_gate_pkg::cmd_release_power_down: next_resp = replay_protected_counter_gate_pkg::resp_refuse; // R8 R9
            replay_protected_counter_gate_pkg::cmd_counter_op:
              next_resp = counter_busy ? replay_protected_counter_gate_pkg::resp_refuse : replay_protected_counter_gate_pkg::resp_accept; // R10
            replay_protected_counter_gate_pkg::cmd_suspend:
              next_resp = no_suspend ? replay_protected_counter_gate_pkg::resp_ignore : replay_protected_counter_gate_pkg::resp_accept; // R7
            default: next_resp = replay_protected_counter_gate_pkg::resp_accept; // R12 R13
          endcase
        end
        replay_protected_counter_gate_pkg::st_suspended: begin
          case (cmd_kind)
            replay_protected_counter_gate_pkg::cmd_write_erase,
            replay_protected_counter_gate_pkg::cmd_chip_erase,
            replay_protected_counter_gate_pkg::cmd_status_write,
            replay_protected_counter_gate_pkg::cmd_suspend,
            replay_protected_counter_gate_pkg::cmd_deep_power_down,
            replay_protected_counter_gate_pkg::cmd_release_power_down: next_resp = replay_protected_counter_gate_pkg::resp_refuse; // R8 R9
            replay_protected_counter_gate_pkg::cmd_counter_op:
              next_resp = counter_busy ? replay_protected_counter_gate_pkg::resp_refuse : replay_protected_counter_gate_pkg::resp_accept; // R10
            default: next_resp = replay_protected_counter_gate_pkg::resp_accept; // R9 R12
          endcase
        end
        default: begin
          case (cmd_kind)
            replay_protected_counter_gate_pkg::cmd_suspend,
            replay_protected_counter_gate_pkg::cmd_resume,
            replay_protected_counter_gate_pkg::cmd_release_power_down: next_resp = replay_protected_counter_gate_pkg::resp_ignore;
            default: next_resp = replay_protected_counter_gate_pkg::resp_accept;
          endcase
        end
      endcase
    end
  end
  assign accept = (next_resp == replay_protected_counter_gate_pkg::resp_accept);

  always_ff @(posedge clk) begin
    if (reset) begin
      resp <= replay_protected_counter_gate_pkg::resp_none;
    end else begin
      resp <= next_resp;
    end
  end

  // ==========================================
  // operation state
  // the write enable latch is not a port: counter commands never look at it
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= replay_protected_counter_gate_pkg::st_idle;
    end else begin
      case (state)
        replay_protected_counter_gate_pkg::st_idle: begin
          if (accept) begin
            case (cmd_kind)
              replay_protected_counter_gate_pkg::cmd_counter_op: state <= replay_protected_counter_gate_pkg::st_counter; // R2 R4
              replay_protected_counter_gate_pkg::cmd_write_erase,
              replay_protected_counter_gate_pkg::cmd_chip_erase,
              replay_protected_counter_gate_pkg::cmd_status_write: state <= replay_protected_counter_gate_pkg::st_pe; // R5
              replay_protected_counter_gate_pkg::cmd_deep_power_down: state <= replay_protected_counter_gate_pkg::st_power_down;
              default: state <= replay_protected_counter_gate_pkg::st_idle;
            endcase
          end
        end
        replay_protected_counter_gate_pkg::st_counter: begin
          if (counter_exec_done) begin
            // a write taken during the counter run continues as program/erase
            state <= (write_in_progress && !pe_done) ? replay_protected_counter_gate_pkg::st_pe
                                                      : replay_protected_counter_gate_pkg::st_idle; // R4
          end
        end
        replay_protected_counter_gate_pkg::st_pe: begin
          if (pe_done) begin
            // a counter run that outlives the program/erase keeps the counter state open
            if ((counter_busy && !counter_exec_done) ||
                (accept && cmd_kind == replay_protected_counter_gate_pkg::cmd_counter_op)) begin
              state <= replay_protected_counter_gate_pkg::st_counter; // R4
            end else begin
              state <= replay_protected_counter_gate_pkg::st_idle; // R5
            end
          end else if (accept && cmd_kind == replay_protected_counter_gate_pkg::cmd_suspend) begin
            state <= replay_protected_counter_gate_pkg::st_suspended; // R6 R7
          end
        end
        replay_protected_counter_gate_pkg::st_suspended: begin
          if (accept && cmd_kind == replay_protected_counter_gate_pkg::cmd_resume) begin
            state <= replay_protected_counter_gate_pkg::st_pe; // R8
          end
        end
        replay_protected_counter_gate_pkg::st_power_down: begin
          if (accept) begin
            state <= replay_protected_counter_gate_pkg::st_idle; // R1
          end
        end
        default: state <= replay_protected_counter_gate_pkg::st_idle; // R18
      endcase
    end
  end

  // ==========================================
  // program/erase and suspend flags
  always_ff @(posedge clk) begin
    if (reset) begin
      write_in_progress <= 1'b0;
      no_suspend <= 1'b0;
    end else if (accept && (cmd_kind == replay_protected_counter_gate_pkg::cmd_write_erase ||
                            cmd_kind == replay_protected_counter_gate_pkg::cmd_chip_erase ||
                            cmd_kind == replay_protected_counter_gate_pkg::cmd_status_write)) begin
      write_in_progress <= 1'b1; // R5
      no_suspend <= (cmd_kind != replay_protected_counter_gate_pkg::cmd_write_erase); // R7
    end else if (pe_done && state != replay_protected_counter_gate_pkg::st_suspended) begin
      write_in_progress <= 1'b0;
      no_suspend <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      suspend_done <= 1'b0;
    end else if (accept && cmd_kind == replay_protected_counter_gate_pkg::cmd_suspend &&
                 state == replay_protected_counter_gate_pkg::st_pe && !pe_done) begin
      suspend_done <= 1'b1; // R6
    end else if (state != replay_protected_counter_gate_pkg::st_suspended) begin
      suspend_done <= 1'b0;
    end else if (accept && cmd_kind == replay_protected_counter_gate_pkg::cmd_resume) begin
      suspend_done <= 1'b0; // R8
    end
  end

  // ==========================================
  // extended status and read answers
  always_ff @(posedge clk) begin
    if (reset) begin
      ext_status <= `EXT_STATUS_RESET;
    end else if (accept && cmd_kind == replay_protected_counter_gate_pkg::cmd_counter_op) begin
      ext_status <= 8'h01; // R17
    end else if (counter_exec_done && counter_busy) begin
      ext_status <= {counter_result[7:1], 1'b0}; // R17
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      read_data <= 8'h00;
    end else if (accept) begin
      case (cmd_kind)
        replay_protected_counter_gate_pkg::cmd_ext_status_read: read_data <= ext_status; // R11 R12
        replay_protected_counter_gate_pkg::cmd_status_read: read_data <= {7'h00, write_in_progress}; // R13
        replay_protected_counter_gate_pkg::cmd_array_read: read_data <= erased_byte; // R14
        default: read_data <= read_data;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      status_reg <= `STATUS_REG_RESET; // R15
      erased_byte <= `ERASED_BYTE; // R14
    end else if (accept && cmd_kind == replay_protected_counter_gate_pkg::cmd_status_write) begin
      status_reg <= status_wr_data;
    end
  end

  // ==========================================
  // checks
  power_down_ignore_a: assert property (@(posedge clk) disable iff (reset) // R1
    state == replay_protected_counter_gate_pkg::st_power_down && cmd_valid &&
    cmd_kind inside {replay_protected_counter_gate_pkg::cmd_counter_op, replay_protected_counter_gate_pkg::cmd_ext_status_read}
    |=> resp == replay_protected_counter_gate_pkg::resp_ignore && state == replay_protected_counter_gate_pkg::st_power_down)
    else $error("command taken in deep power-down");
  counter_entry_a: assert property (@(posedge clk) disable iff (reset) // R4
    state == replay_protected_counter_gate_pkg::st_idle && cmd_valid && cmd_kind == replay_protected_counter_gate_pkg::cmd_counter_op
    |=> state == replay_protected_counter_gate_pkg::st_counter && ext_status[0])
    else $error("counter state not entered");
  counter_suspend_a: assert property (@(posedge clk) disable iff (reset) // R4
    state == replay_protected_counter_gate_pkg::st_counter && !counter_exec_done && cmd_valid &&
    cmd_kind == replay_protected_counter_gate_pkg::cmd_suspend |=> state == replay_protected_counter_gate_pkg::st_counter)
    else $error("suspend acted in counter state");
  pe_exit_a: assert property (@(posedge clk) disable iff (reset) // R5
    state == replay_protected_counter_gate_pkg::st_pe && pe_done |=> !write_in_progress &&
    state == (ext_status[0] ? replay_protected_counter_gate_pkg::st_counter : replay_protected_counter_gate_pkg::st_idle))
    else $error("program/erase did not end");
  suspend_entry_a: assert property (@(posedge clk) disable iff (reset) // R6
    $rose(suspend_done) |-> state == replay_protected_counter_gate_pkg::st_suspended)
    else $error("suspend flag without suspended state");
  chip_erase_hold_a: assert property (@(posedge clk) disable iff (reset) // R7
    state == replay_protected_counter_gate_pkg::st_pe && no_suspend && !pe_done && cmd_valid &&
    cmd_kind == replay_protected_counter_gate_pkg::cmd_suspend |=> state == replay_protected_counter_gate_pkg::st_pe)
    else $error("non-suspendable operation suspended");
  resume_back_a: assert property (@(posedge clk) disable iff (reset) // R8
    state == replay_protected_counter_gate_pkg::st_suspended && cmd_valid && cmd_kind == replay_protected_counter_gate_pkg::cmd_resume
    |=> state == replay_protected_counter_gate_pkg::st_pe && !suspend_done)
    else $error("resume did not return");
  pe_refuse_a: assert property (@(posedge clk) disable iff (reset) // R9
    state == replay_protected_counter_gate_pkg::st_pe && cmd_valid && cmd_kind == replay_protected_counter_gate_pkg::cmd_array_read
    |=> resp == replay_protected_counter_gate_pkg::resp_refuse)
    else $error("read taken during program/erase");
  counter_refuse_a: assert property (@(posedge clk) disable iff (reset) // R10
    counter_busy && cmd_valid && cmd_kind == replay_protected_counter_gate_pkg::cmd_counter_op
    |=> resp == replay_protected_counter_gate_pkg::resp_refuse)
    else $error("second counter command taken");
  ext_read_a: assert property (@(posedge clk) disable iff (reset) // R11
    state != replay_protected_counter_gate_pkg::st_power_down && cmd_valid &&
    cmd_kind == replay_protected_counter_gate_pkg::cmd_ext_status_read |=> read_data == $past(ext_status))
    else $error("extended read wrong");
  one_state_a: assert property (@(posedge clk) disable iff (reset) // R18
    $onehot(state))
    else $error("state not one-hot");
endmodule : replay_protected_counter_state_gating

// ===== verif/flash_engine_model.sv
// behavioural counter and program/erase engines that answer the gating block
`timescale 1ns/1ps

module flash_engine_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic counter_busy,
  input wire logic pe_active,
  input wire logic [7:0] cnt_delay,
  input wire logic [7:0] pe_delay,
  input wire logic [7:0] result_in,
  output logic counter_exec_done,
  output logic [7:0] counter_result,
  output logic pe_done
);
  logic [7:0] cnt_age;
  logic [7:0] pe_age;

  // ==========
  // engines
  // result bus toggles outside the done pulse so a stale value never looks valid
  always_ff @(posedge clk) begin
    counter_exec_done <= 1'b0;
    pe_done <= 1'b0;
    counter_result <= ~counter_result;
    if (reset) begin
      cnt_age <= 8'h00;
      pe_age <= 8'h00;
      counter_result <= 8'h5a;
    end else begin
      if (!counter_busy) begin
        cnt_age <= 8'h00;
      end else if (cnt_age >= cnt_delay) begin
        counter_exec_done <= 1'b1;
        counter_result <= result_in;
        cnt_age <= 8'h00;
      end else begin
        cnt_age <= cnt_age + 8'h01;
      end
      // progress pauses while suspended, resume carries on
      if (pe_active && pe_age >= pe_delay) begin
        pe_done <= 1'b1;
        pe_age <= 8'h00;
      end else if (pe_active) begin
        pe_age <= pe_age + 8'h01;
      end
    end
  end
endmodule : flash_engine_model

// ===== verif/replay_protected_counter_state_gating_tb_top.sv
// self-checking bench of the state gating block
`timescale 1ns/1ps
`include "replay_protected_counter_gate_map.svh"
`define check_eq(n, got, exp) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
      fail_count++; \
      $display("mismatch %s expected %h seen %h", n, exp, got); \
    end \
  end

module replay_protected_counter_state_gating_tb_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic cmd_valid = 1'b0;
  replay_protected_counter_gate_pkg::cmd_e cmd_kind = replay_protected_counter_gate_pkg::cmd_status_read;
  logic [23:0] status_wr_data = 24'h000000;
  logic [7:0] result_in = 8'h00, cnt_delay = 8'h08, pe_delay = 8'h10;
  logic counter_exec_done, pe_done, write_in_progress, suspend_done;
  logic [7:0] counter_result, read_data, ext_status, erased_byte, e_ext, e_rd;
  replay_protected_counter_gate_pkg::state_e state;
  replay_protected_counter_gate_pkg::resp_e resp;
  logic [23:0] status_reg, e_sreg;
  logic [4:0] e_state;
  logic [1:0] e_resp;
  logic e_wip, e_ce, e_pend, e_rdok;
  logic [3:0] kind;
  int fail_count = 0, n_tests = 0, cycles = 0;
  // 15 stands for a quiet stretch
  int plan[$] = {9, 0, 1, 2, 10, 0, 0, 9, 7, 8, 4, 6, 1, 15, 15, 6, 7, 3, 8, 2, 9, 10, 15, 15,
    4, 7, 4, 7, 6, 9, 3, 2, 0, 0, 15, 1, 8, 0, 5, 15, 15, 5, 7, 15, 15};

  always #12.5 clk = ~clk;

  replay_protected_counter_state_gating u_replay_protected_counter_state_gating (.clk(clk), .reset(reset), .cmd_valid(cmd_valid),
    .cmd_kind(cmd_kind), .status_wr_data(status_wr_data), .counter_exec_done(counter_exec_done),
    .counter_result(counter_result), .pe_done(pe_done), .state(state), .resp(resp),
    .read_data(read_data), .ext_status(ext_status), .write_in_progress(write_in_progress),
    .suspend_done(suspend_done), .status_reg(status_reg), .erased_byte(erased_byte));

  flash_engine_model u_flash_engine_model (.clk(clk), .reset(reset),
    .counter_busy(ext_status[0]), .pe_active(state == replay_protected_counter_gate_pkg::st_pe),
    .cnt_delay(cnt_delay), .pe_delay(pe_delay), .result_in(result_in),
    .counter_exec_done(counter_exec_done), .counter_result(counter_result), .pe_done(pe_done));

  // ==========
  // expected behaviour
  task automatic gate(input logic [3:0] k);
    logic [1:0] r;
    r = 2'h1;
    case (e_state)
      5'h10: if (k == 4'ha) e_state = 5'h01; else r = 2'h2;
      5'h02: if (k inside {4'h7, 4'h8, 4'ha}) r = 2'h2; else if (k inside {4'h0, 4'h9}) r = 2'h3;
      5'h04: if (k inside {[4'h3:4'h6], [4'h8:4'ha]} || (k == 4'h0 && e_ext[0])) r = 2'h3;
        else if (k == 4'h7 && e_ce) r = 2'h2;
      5'h08: if (k inside {[4'h4:4'h7], 4'h9, 4'ha} || (k == 4'h0 && e_ext[0])) r = 2'h3;
      default: if (k inside {4'h7, 4'h8, 4'ha}) r = 2'h2;
    endcase
    if (r == 2'h1) begin
      case (k)
        4'h0: begin
          e_ext = 8'h01;
          if (e_state == 5'h01) e_state = 5'h02;
        end
        4'h1: {e_rdok, e_rd} = {1'b1, e_ext};
        4'h2: {e_rdok, e_rd} = {1'b1, 7'h00, e_wip};
        4'h3: {e_rdok, e_rd} = {1'b1, 8'hff};
        4'h4, 4'h5, 4'h6: begin
          e_wip = 1'b1;
          e_ce = (k != 4'h4);
          if (k == 4'h6) e_sreg = status_wr_data;
          if (e_state == 5'h01) e_state = 5'h04; else e_pend = 1'b1;
        end
        4'h7: e_state = 5'h08;
        4'h8: e_state = 5'h04;
        4'h9: e_state = 5'h10;
        default: e_state = 5'h01;
      endcase
    end
    e_resp = r;
  endtask : gate

  always @(posedge clk) begin
    if (reset) begin
      {e_state, e_resp, e_ext, e_rd} = {5'h01, 2'h0, 8'h00, 8'h00};
      {e_wip, e_ce, e_pend, e_rdok} = 4'h1;
      e_sreg = 24'h200200;
    end else begin
      e_resp = 2'h0;
      if (counter_exec_done && e_ext[0]) begin
        e_ext = {counter_result[7:1], 1'b0};
        if (e_state == 5'h02) e_state = e_pend ? 5'h04 : 5'h01;
        e_pend = 1'b0;
      end
      if (pe_done && e_state == 5'h04) {e_wip, e_state} = {1'b0, e_ext[0] ? 5'h02 : 5'h01};
      if (cmd_valid) gate(cmd_kind);
    end
  end

  // ==========
  // checks and stimulus
  task automatic check_all;
    `check_eq("state", state, e_state)
    `check_eq("resp", resp, e_resp)
    `check_eq("ext busy", ext_status[0], e_ext[0])
    if (!e_ext[0]) `check_eq("ext status", ext_status, e_ext)
    `check_eq("wip", write_in_progress, e_wip)
    `check_eq("suspend done", suspend_done, e_state == 5'h08)
    `check_eq("status reg", status_reg, e_sreg)
    `check_eq("erased", erased_byte, 8'hff)
    if (e_rdok) `check_eq("read data", read_data, e_rd)
  endtask : check_all

  task automatic step(input logic [3:0] k);
    @(negedge clk);
    check_all();
    // a done pulse and a command never share an edge
    while (counter_exec_done || pe_done) begin
      cmd_valid = 1'b0;
      @(negedge clk);
      check_all();
    end
    cmd_valid = (k != 4'hf);
    if (k != 4'hf) cmd_kind = replay_protected_counter_gate_pkg::cmd_e'(k);
    status_wr_data = 24'($urandom);
    result_in = 8'($urandom);
  endtask : step

  task automatic rand_steps(input int n);
    repeat (n) begin
      kind = 4'($urandom_range(10));
      if (kind == 4'h0 && e_state inside {5'h04, 5'h08}) kind = 4'h2;
      if ($urandom_range(3) == 0) kind = 4'hf;
      cnt_delay = 8'($urandom_range(24, 2));
      pe_delay = 8'($urandom_range(40, 2));
      step(kind);
    end
  endtask : rand_steps

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      fail_count++;
      give_verdict();
    end
  end

  initial begin
    void'($urandom(93127));
    repeat (4) @(negedge clk);
    reset = 1'b0;
    repeat (`POWER_UP_WAIT_CYCLES) @(negedge clk);
    {cnt_delay, pe_delay} = {8'h14, 8'h64};
    foreach (plan[i]) begin
      if (plan[i] == 15) repeat (70) step(4'hf);
      else step(4'(plan[i]));
    end
    // discouraged but legal: a counter run that outlasts a short program
    {cnt_delay, pe_delay} = {8'h40, 8'h08};
    step(4'h4);
    step(4'h0);
    repeat (90) step(4'hf);
    rand_steps(3000);
    reset = 1'b1;
    repeat (4) step(4'hf);
    reset = 1'b0;
    rand_steps(300);
    give_verdict();
  end
endmodule : replay_protected_counter_state_gating_tb_top
